//--- ibp_master.sv
// Two-wire bus master: START, address, byte transfer, STOP
`timescale 1ns/100ps
`default_nettype none
module ibp_master
	import ibp_pkg::*;
(
	input  wire logic       CLK_I,
	input  wire logic       RESETN_I,
	input  wire logic       CMD_VALID_I,
	input  wire logic [1:0] CMD_OP_I,
	input  wire logic [9:0] CMD_ADDR_I,
	input  wire logic       CMD_TEN_I,
	input  wire logic       CMD_RW_I,
	input  wire logic [7:0] CMD_DATA_I,
	input  wire logic       CMD_NACK_I,
	output var  logic       CMD_READY_O,
	output var  logic       DONE_O,
	output var  logic [7:0] RDATA_O,
	output var  logic       ACK_ERR_O,
	output var  logic       REFUSED_O,
	output var  logic       ARB_LOST_O,
	output var  logic       BUSY_O,
	input  wire logic       SCL_I,
	output var  logic       SCL_O,
	output var  logic       SCL_OE_O,
	input  wire logic       SDA_I,
	output var  logic       SDA_O,
	output var  logic       SDA_OE_O
);
	ibp_state_e  state;
	ibp_state_e  next_state;
	logic [1:0]  ph;
	logic [1:0]  next_ph;
	logic [15:0] qcnt;
	logic [15:0] next_qcnt;
	logic [8:0]  sh_tx;
	logic [8:0]  next_sh_tx;
	logic [8:0]  sh_rx;
	logic [8:0]  next_sh_rx;
	logic [3:0]  bitn;
	logic [3:0]  next_bitn;
	logic [1:0]  op;
	logic [1:0]  next_op;
	logic [1:0]  aseq;
	logic [1:0]  next_aseq;
	logic [9:0]  addr;
	logic [9:0]  next_addr;
	logic        ten;
	logic        next_ten;
	logic        rw;
	logic        next_rw;
	logic        owner;
	logic        next_owner;
	logic        next_scl_oe;
	logic        next_sda_oe;
	logic        next_ready;
	logic        next_done;
	logic [7:0]  next_rdata;
	logic        next_ack_err;
	logic        next_refused;
	logic        next_arb;
	logic        scl_s;
	logic        sda_s;
	logic        scl_q;
	logic        sda_q;
	logic        next_busy;
	logic        qdone;

	// Pins filtered before any decision is taken on them
	ibp_sync u_sync_scl (.clk_i(CLK_I), .resetn_i(RESETN_I), .d_i(SCL_I), .q_o(scl_s));
	ibp_sync u_sync_sda (.clk_i(CLK_I), .resetn_i(RESETN_I), .d_i(SDA_I), .q_o(sda_s));

	// Address byte for a given step, with a released bit for the acknowledge
	function automatic logic [8:0] addr_byte(input logic [1:0] step, input logic [9:0] a,
		input logic t, input logic r);
		logic [8:0] b;
		b = {a[6:0], r, 1'b1};
		if (t) begin
			b = {TEN_PREFIX, a[9:8], (step == STEP_REREAD) ? RW_READ : RW_WRITE, 1'b1};
			if (step == STEP_SECOND)
				b = {a[7:0], 1'b1};
		end
		return b;
	endfunction

	// Bus monitor next value
	always_comb begin
		next_busy = BUSY_O;
		if (scl_s && scl_q && sda_q && !sda_s)
			next_busy = 1'b1;
		if (scl_s && scl_q && !sda_q && sda_s)
			next_busy = 1'b0;
	end

	// Bus monitor registers
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			scl_q  <= 1'b1;
			sda_q  <= 1'b1;
			BUSY_O <= 1'b0;
		end else begin
			scl_q  <= scl_s;
			sda_q  <= sda_s;
			BUSY_O <= next_busy;
		end
	end

	assign qdone = (qcnt == QUARTER_CYC - 16'h1);

	// Sequencer next values
	always_comb begin
		next_state   = state;
		next_ph      = ph;
		next_qcnt    = qcnt;
		next_sh_tx   = sh_tx;
		next_sh_rx   = sh_rx;
		next_bitn    = bitn;
		next_op      = op;
		next_aseq    = aseq;
		next_addr    = addr;
		next_ten     = ten;
		next_rw      = rw;
		next_owner   = owner;
		next_scl_oe  = SCL_OE_O;
		next_sda_oe  = SDA_OE_O;
		next_done    = 1'b0;
		next_rdata   = RDATA_O;
		next_ack_err = ACK_ERR_O;
		next_refused = 1'b0;
		next_arb     = 1'b0;
		case (state)
			S_IDLE: begin
				next_qcnt = 16'h0;
				next_ph   = 2'h0;
				if (CMD_VALID_I && CMD_READY_O) begin
					next_op   = CMD_OP_I;
					next_bitn = 4'h0;
					case (CMD_OP_I)
						OP_ADDR: begin
							if (!CMD_TEN_I && ibp_reserved7(CMD_ADDR_I[6:0], CMD_RW_I)) begin
								next_refused = 1'b1;
								next_done    = 1'b1;
							end else begin
								next_addr  = CMD_ADDR_I;
								next_ten   = CMD_TEN_I;
								next_rw    = CMD_RW_I;
								next_aseq  = STEP_FIRST;
								next_state = S_START;
							end
						end
						OP_WRITE, OP_READ: begin
							if (!owner) begin
								next_refused = 1'b1;
								next_done    = 1'b1;
							end else begin
								next_sh_tx = (CMD_OP_I == OP_WRITE) ? {CMD_DATA_I, 1'b1} : {8'hFF, CMD_NACK_I};
								next_state = S_BIT;
							end
						end
						default: begin
							// STOP only from an owned bus
							if (!owner) begin
								next_refused = 1'b1;
								next_done    = 1'b1;
							end else begin
								next_state = S_STOP;
							end
						end
					endcase
				end
			end
			S_START: begin
				case (ph)
					2'h0: begin
						// release SDA for repeated START while SCL low
						next_sda_oe = 1'b0;
						// fresh START waits for an idle bus
						if (owner || (!BUSY_O && scl_s && sda_s))
							next_qcnt = qcnt + 16'h1;
						if (qdone) begin
							next_qcnt   = 16'h0;
							next_ph     = 2'h1;
							next_scl_oe = 1'b0;
						end
					end
					2'h1: begin
						// Wait out any clock stretching before the high quarter
						if (scl_s)
							next_qcnt = qcnt + 16'h1;
						if (qdone && scl_s) begin
							next_qcnt = 16'h0;
							next_ph   = 2'h2;
							next_sda_oe = 1'b1;
						end
					end
					2'h2: begin
						next_qcnt = qcnt + 16'h1;
						if (qdone) begin
							next_qcnt   = 16'h0;
							next_ph     = 2'h3;
							next_scl_oe = 1'b1;
						end
					end
					default: begin
						next_qcnt = qcnt + 16'h1;
						if (qdone) begin
							next_qcnt  = 16'h0;
							next_ph    = 2'h0;
							next_owner = 1'b1;
							next_bitn  = 4'h0;
							// first byte after START is the address
							next_sh_tx = addr_byte(aseq, addr, ten, rw);
							next_state = S_BIT;
						end
					end
				endcase
			end
			S_BIT: begin
				case (ph)
					2'h0: begin
						next_qcnt = qcnt + 16'h1;
						if (qdone) begin
							next_qcnt = 16'h0;
							next_ph   = 2'h1;
							// data changes a quarter into SCL low
							// ninth bit of a transmitted byte is released
							next_sda_oe = ~sh_tx[8];
						end
					end
					2'h1: begin
						next_qcnt = qcnt + 16'h1;
						if (qdone) begin
							next_qcnt   = 16'h0;
							next_ph     = 2'h2;
							next_scl_oe = 1'b0;
						end
					end
					2'h2: begin
						if (scl_s)
							next_qcnt = qcnt + 16'h1;
						if (qdone && scl_s) begin
							next_qcnt  = 16'h0;
							next_ph    = 2'h3;
							next_sh_rx = {sh_rx[7:0], sda_s};
							// released line sensed low: back off
							if (op != OP_READ && bitn != LAST_BIT && sh_tx[8] && !sda_s) begin
								next_arb    = 1'b1;
								next_done   = 1'b1;
								next_owner  = 1'b0;
								next_scl_oe = 1'b0;
								next_sda_oe = 1'b0;
								next_state  = S_IDLE;
							end
						end
					end
					default: begin
						next_qcnt = qcnt + 16'h1;
						if (qdone) begin
							next_qcnt   = 16'h0;
							next_ph     = 2'h0;
							next_scl_oe = 1'b1;
							next_sh_tx = {sh_tx[7:0], 1'b1};
							next_bitn = bitn + 4'h1;
							if (bitn == LAST_BIT) begin
								next_bitn = 4'h0;
								if (op == OP_ADDR) begin
									// NACK on address ends the command
									if (sh_rx[0]) begin
										next_ack_err = 1'b1;
										next_done    = 1'b1;
										next_state   = S_IDLE;
									end else if (ten && aseq == STEP_FIRST) begin
										next_aseq  = STEP_SECOND;
										next_sh_tx = addr_byte(STEP_SECOND, addr, ten, rw);
									end else if (ten && aseq == STEP_SECOND && rw == RW_READ) begin
										// repeated START, header resent as read
										next_aseq  = STEP_REREAD;
										next_state = S_START;
									end else begin
										next_ack_err = 1'b0;
										next_done    = 1'b1;
										next_state   = S_IDLE;
									end
								end else begin
									next_rdata   = sh_rx[8:1];
									next_ack_err = (op == OP_WRITE) ? sh_rx[0] : 1'b0;
									next_done    = 1'b1;
									next_state   = S_IDLE;
								end
							end
						end
					end
				endcase
			end
			S_STOP: begin
				next_qcnt = qcnt + 16'h1;
				case (ph)
					2'h0: begin
						next_sda_oe = 1'b1;
						if (qdone) begin
							next_qcnt   = 16'h0;
							next_ph     = 2'h1;
							next_scl_oe = 1'b0;
						end
					end
					2'h1: begin
						if (!scl_s)
							next_qcnt = 16'h0;
						if (qdone && scl_s) begin
							next_qcnt = 16'h0;
							next_ph   = 2'h2;
							next_sda_oe = 1'b0;
						end
					end
					default: begin
						if (qdone) begin
							next_qcnt  = 16'h0;
							next_ph    = 2'h0;
							next_owner = 1'b0;
							next_done  = 1'b1;
							next_state = S_IDLE;
						end
					end
				endcase
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
		next_ready = (next_state == S_IDLE);
	end

	// Sequencer registers; open-drain data outputs are always low
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state       <= S_IDLE;
			ph          <= 2'h0;
			qcnt        <= 16'h0;
			sh_tx       <= 9'h1FF;
			sh_rx       <= 9'h000;
			bitn        <= 4'h0;
			op          <= OP_ADDR;
			aseq        <= STEP_FIRST;
			addr        <= 10'h000;
			ten         <= 1'b0;
			rw          <= RW_WRITE;
			owner       <= 1'b0;
			SCL_OE_O    <= 1'b0;
			SDA_OE_O    <= 1'b0;
			SCL_O       <= 1'b0;
			SDA_O       <= 1'b0;
			CMD_READY_O <= 1'b0;
			DONE_O      <= 1'b0;
			RDATA_O     <= 8'h00;
			ACK_ERR_O   <= 1'b0;
			REFUSED_O   <= 1'b0;
			ARB_LOST_O  <= 1'b0;
		end else begin
			state       <= next_state;
			ph          <= next_ph;
			qcnt        <= next_qcnt;
			sh_tx       <= next_sh_tx;
			sh_rx       <= next_sh_rx;
			bitn        <= next_bitn;
			op          <= next_op;
			aseq        <= next_aseq;
			addr        <= next_addr;
			ten         <= next_ten;
			rw          <= next_rw;
			owner       <= next_owner;
			SCL_OE_O    <= next_scl_oe;
			SDA_OE_O    <= next_sda_oe;
			SCL_O       <= 1'b0;
			SDA_O       <= 1'b0;
			CMD_READY_O <= next_ready;
			DONE_O      <= next_done;
			RDATA_O     <= next_rdata;
			ACK_ERR_O   <= next_ack_err;
			REFUSED_O   <= next_refused;
			ARB_LOST_O  <= next_arb;
		end
	end

	// Checks on the driven pins and shift data
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);

	property p_start_edge;
		$rose(SDA_OE_O) && state == S_START |-> !SCL_OE_O && ph == 2'h2;
	endproperty
	a_start_edge: assert property (p_start_edge) else $error("START edge with SCL held low");

	property p_stop_edge;
		$fell(SDA_OE_O) && state == S_STOP |-> !SCL_OE_O && scl_s;
	endproperty
	a_stop_edge: assert property (p_stop_edge) else $error("STOP edge without SCL high");

	property p_sda_stable;
		state == S_BIT && !SCL_OE_O && $past(!SCL_OE_O) |-> $stable(SDA_OE_O);
	endproperty
	a_sda_stable: assert property (p_sda_stable) else $error("SDA moved while SCL released");

	property p_one_bit;
		state == S_BIT && $past(state == S_BIT) && bitn != $past(bitn) |-> $rose(SCL_OE_O);
	endproperty
	a_one_bit: assert property (p_one_bit) else $error("Bit count moved without a clock pulse");

	property p_wait_idle;
		$rose(SDA_OE_O) && state == S_START && !owner |-> $past(!BUSY_O, 2);
	endproperty
	a_wait_idle: assert property (p_wait_idle) else $error("START on a busy bus");

	property p_seven_bit;
		$rose(state == S_BIT) && op == OP_ADDR && !ten |-> sh_tx == {addr[6:0], rw, 1'b1};
	endproperty
	a_seven_bit: assert property (p_seven_bit) else $error("Address byte malformed");

	property p_ack_release;
		state == S_BIT && bitn == LAST_BIT && op != OP_READ && ph != 2'h0 |-> !SDA_OE_O;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("SDA held in acknowledge slot");

	property p_msb_first;
		state == S_BIT && $past(state == S_BIT) && bitn == $past(bitn) + 4'h1 |-> sh_tx == {$past(sh_tx[7:0]), 1'b1};
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("Shift order wrong");

	property p_ten_header;
		$rose(state == S_BIT) && op == OP_ADDR && ten |-> sh_tx[8:4] == TEN_PREFIX && sh_tx[3:2] == addr[9:8];
	endproperty
	a_ten_header: assert property (p_ten_header) else $error("Ten-bit header malformed");

	property p_ten_reread;
		$rose(state == S_BIT) && aseq == STEP_REREAD |-> sh_tx[1] == RW_READ && ten && rw == RW_READ;
	endproperty
	a_ten_reread: assert property (p_ten_reread) else $error("Re-read header lacks read bit");

	property p_arb_release;
		ARB_LOST_O |-> !SCL_OE_O && !SDA_OE_O && !owner && state == S_IDLE;
	endproperty
	a_arb_release: assert property (p_arb_release) else $error("Lines held after arbitration loss");

	c_write_done: cover property (DONE_O && op == OP_WRITE && !ACK_ERR_O);
	c_ten_read:   cover property ($rose(state == S_BIT) && aseq == STEP_REREAD);
	c_arb_lost:   cover property (ARB_LOST_O);
	c_stop_done:  cover property (DONE_O && op == OP_STOP);

endmodule // ibp_master
`default_nettype wire

//--- ibp_pkg.sv
// Constants and helpers for the two-wire bus master engine
`default_nettype none
package ibp_pkg;

	// Bit timing, standard mode
	// quarter count sets bus rate
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          T_QUARTER_NS  = 2500;
	localparam logic [15:0] QUARTER_CYC   = 16'((T_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// Command opcodes
	localparam logic [1:0] OP_ADDR  = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_READ  = 2'h2;
	localparam logic [1:0] OP_STOP  = 2'h3;

	// Address byte fields
	localparam logic [4:0] TEN_PREFIX = 5'h1E;
	localparam logic       RW_READ    = 1'h1;
	localparam logic       RW_WRITE   = 1'h0;
	localparam logic [3:0] LAST_BIT   = 4'h8;

	// Address sequencing steps
	localparam logic [1:0] STEP_FIRST  = 2'h0;
	localparam logic [1:0] STEP_SECOND = 2'h1;
	localparam logic [1:0] STEP_REREAD = 2'h3;

	typedef enum logic [1:0] {S_IDLE, S_START, S_BIT, S_STOP} ibp_state_e;

	// Seven-bit patterns that must not be used as plain slave addresses
	function automatic logic ibp_reserved7(input logic [6:0] a, input logic rw);
		logic res;
		res = 1'b0;
		if (a[6:3] == 4'h0 && a != 7'h00)
			res = 1'b1;
		if (a == 7'h00 && rw == RW_READ)
			res = 1'b1;
		if (a[6:3] == 4'hF)
			res = 1'b1;
		return res;
	endfunction

endpackage
`default_nettype wire

//--- ibp_slave_model.sv
// Behavioural slave device on the two-wire bus
`timescale 1ns/100ps
`default_nettype none
module ibp_slave_model
	import ibp_pkg::*;
#(
	parameter logic [6:0] ADDR7      = 7'h2A,
	parameter logic [9:0] ADDR10     = 10'h2C3,
	parameter logic [7:0] TX_BYTE    = 8'h5C,
	parameter int         STRETCH_NS = 0
)(
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output var  logic       scl_oe_o,
	output var  logic       sda_oe_o,
	output var  logic [7:0] rx_o,
	output var  logic [7:0] addr_o,
	output var  logic       sel10_o
);
	logic [7:0] b;
	int         cond;
	int         mode;
	logic       na;

	// one bit per pulse; SDA moving while SCL high is S, Sr or P
	task automatic get_byte(output logic [7:0] v, output int c);
		c = 0;
		v = 8'h00;
		for (int i = 0; i < 8; i++) begin
			@(posedge scl_i);
			v = {v[6:0], sda_i};
			@(negedge scl_i or sda_i);
			if (scl_i) begin
				c = sda_i ? 2 : 1;
				return;
			end
		end
	endtask

	// acknowledge; slow mode holds SCL low to stretch
	task automatic ack();
		#200 sda_oe_o = 1'b1;
		if (STRETCH_NS > 0) begin
			scl_oe_o = 1'b1;
			#(STRETCH_NS) scl_oe_o = 1'b0;
		end
		@(negedge scl_i);
		#200 sda_oe_o = 1'b0;
	endtask

	// MSB first, changed only while SCL low, released for the answer
	task automatic send(input logic [7:0] v, output logic n);
		for (int i = 7; i >= 0; i--) begin
			#200 sda_oe_o = ~v[i];
			@(negedge scl_i);
		end
		#200 sda_oe_o = 1'b0;
		@(posedge scl_i);
		n = sda_i;
		@(negedge scl_i);
	endtask

	// Frame walker: address phase then data phase until S, Sr or P
	initial begin
		scl_oe_o = 1'b0;
		sda_oe_o = 1'b0;
		rx_o = 8'h00;
		addr_o = 8'h00;
		sel10_o = 1'b0;
		forever begin
			@(negedge sda_i iff scl_i === 1'b1);
			cond = 1;
			while (cond == 1) begin
				get_byte(b, cond);
				if (cond != 0)
					continue;
				addr_o = b;
				mode = 2;
				// own address or general call write
				if (b[7:1] == ADDR7 || b == 8'h00) begin
					ack();
					mode = int'(b[0]);
				// header then low byte, both acknowledged
				end else if (b == {TEN_PREFIX, ADDR10[9:8], RW_WRITE}) begin
					ack();
					get_byte(b, cond);
					if (cond == 0 && b == ADDR10[7:0]) begin
						ack();
						sel10_o = 1'b1;
						mode = 0;
					end
				end else if (b == {TEN_PREFIX, ADDR10[9:8], RW_READ} && sel10_o) begin
					ack();
					mode = 1;
				end
				// any number of bytes; passive after a NACK
				while (cond == 0) begin
					if (mode == 1) begin
						send(TX_BYTE, na);
						mode = na ? 2 : 1;
					end else begin
						get_byte(b, cond);
						if (cond == 0 && mode == 0) begin
							rx_o = b;
							ack();
						end
					end
				end
			end
			sel10_o = 1'b0;
		end
	end
endmodule // ibp_slave_model
`default_nettype wire

//--- ibp_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module ibp_sync
	import ibp_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic resetn_i,
	input  wire logic d_i,
	output var  logic q_o
);
	logic s1;
	logic s2;
	logic s3;
	logic next_q;

	// Output follows only once stages two and three agree
	always_comb begin
		next_q = q_o;
		if (s2 == s3)
			next_q = s3;
	end

	// Idle bus level is high, so reset to one
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s1  <= 1'b1;
			s2  <= 1'b1;
			s3  <= 1'b1;
			q_o <= 1'b1;
		end else begin
			s1  <= d_i;
			s2  <= s1;
			s3  <= s2;
			q_o <= next_q;
		end
	end
endmodule // ibp_sync
`default_nettype wire

//--- test_ibp_master.sv
// Self-checking bench for the two-wire bus master engine
`timescale 1ns/100ps
`default_nettype none
module test_ibp_master
	import ibp_pkg::*;
;
	localparam logic [6:0] SLAVE7   = 7'h2A;
	localparam logic [9:0] SLAVE10  = 10'h2C3;
	localparam logic [7:0] SLAVE_TX = 8'h5C;
	logic       clk = 1'b0;
	logic       resetn, valid, ten, rw, nack;
	logic [1:0] op;
	logic [9:0] addr;
	logic [7:0] data, rdata, m_rx, m_addr, got_rdata;
	logic       ready, done, ack_err, refused, arb_lost, busy, scl_o, sda_o, scl_oe, sda_oe;
	logic       m_scl_oe, m_sda_oe, m_sel10, got_err, got_ref, got_arb, rival;
	int         failures, checks;
	// Open-drain lines with pull-up
	wire        scl_bus = ~(scl_oe | m_scl_oe);
	wire        sda_bus = ~(sda_oe | m_sda_oe | rival);

	ibp_master ibp_master_i (
		.CLK_I       (clk),
		.RESETN_I    (resetn),
		.CMD_VALID_I (valid),
		.CMD_OP_I    (op),
		.CMD_ADDR_I  (addr),
		.CMD_TEN_I   (ten),
		.CMD_RW_I    (rw),
		.CMD_DATA_I  (data),
		.CMD_NACK_I  (nack),
		.CMD_READY_O (ready),
		.DONE_O      (done),
		.RDATA_O     (rdata),
		.ACK_ERR_O   (ack_err),
		.REFUSED_O   (refused),
		.ARB_LOST_O  (arb_lost),
		.BUSY_O      (busy),
		.SCL_I       (scl_bus),
		.SCL_O       (scl_o),
		.SCL_OE_O    (scl_oe),
		.SDA_I       (sda_bus),
		.SDA_O       (sda_o),
		.SDA_OE_O    (sda_oe)
	);

	// Slow slave: stretches SCL on every acknowledge
	ibp_slave_model #(.ADDR7(SLAVE7), .ADDR10(SLAVE10), .TX_BYTE(SLAVE_TX), .STRETCH_NS(8000)) ibp_slave_model_i (
		.scl_i    (scl_bus),
		.sda_i    (sda_bus),
		.scl_oe_o (m_scl_oe),
		.sda_oe_o (m_sda_oe),
		.rx_o     (m_rx),
		.addr_o   (m_addr),
		.sel10_o  (m_sel10)
	);

	always #5 clk = ~clk;

	task automatic print_verdict();
		$display("Counts: %0d checks, %0d failures", checks, failures);
		if (failures == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bit(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask

	// One command: wait for ready, hold valid for one cycle, wait bounded for done
	task automatic issue(input logic [1:0] o, input logic [9:0] a, input logic t, input logic r,
		input logic [7:0] d, input logic n);
		int k;
		k = 0;
		while (ready !== 1'b1 && k < 100) begin
			@(negedge clk);
			k++;
		end
		if (ready !== 1'b1) begin
			check_bit("ready before command", 1'b1, ready);
			print_verdict();
		end
		@(posedge clk);
		valid <= 1'b1;
		op <= o;
		addr <= a;
		ten <= t;
		rw <= r;
		data <= d;
		nack <= n;
		@(posedge clk);
		valid <= 1'b0;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (done !== 1'b1 && k < 80000);
		if (done !== 1'b1) begin
			check_bit("done pulse", 1'b1, done);
			print_verdict();
		end
		got_rdata = rdata;
		got_err = ack_err;
		got_ref = refused;
		got_arb = arb_lost;
	endtask

	// Reserved addresses and commands without the bus are refused
	task automatic t_refuse();
		logic [6:0] bad [7] = '{7'h01, 7'h02, 7'h03, 7'h04, 7'h07, 7'h78, 7'h7F};
		foreach (bad[i]) begin
			issue(OP_ADDR, {3'h0, bad[i]}, 1'b0, RW_WRITE, 8'h00, 1'b0);
			check_bit("reserved address refused", 1'b1, got_ref);
			check_bit("bus untouched", 1'b0, busy);
		end
		issue(OP_ADDR, 10'h000, 1'b0, RW_READ, 8'h00, 1'b0);
		check_bit("start byte refused", 1'b1, got_ref);
		issue(OP_WRITE, 10'h000, 1'b0, RW_WRITE, 8'h55, 1'b0);
		check_bit("write without start refused", 1'b1, got_ref);
		issue(OP_STOP, 10'h000, 1'b0, RW_WRITE, 8'h00, 1'b0);
		check_bit("stop without bus refused", 1'b1, got_ref);
		$display("test refuse done, failures %0d", failures);
	endtask

	// 7-bit write, two bytes, Sr to an absent slave, STOP
	task automatic t_write7();
		issue(OP_ADDR, {3'h0, SLAVE7}, 1'b0, RW_WRITE, 8'h00, 1'b0);
		check_bit("address ack error", 1'b0, got_err);
		check_byte("address byte at slave", {SLAVE7, RW_WRITE}, m_addr);
		check_bit("busy after start", 1'b1, busy);
		issue(OP_WRITE, 10'h000, 1'b0, RW_WRITE, 8'hA5, 1'b0);
		check_bit("write ack error", 1'b0, got_err);
		check_byte("first byte at slave", 8'hA5, m_rx);
		issue(OP_WRITE, 10'h000, 1'b0, RW_WRITE, 8'h3C, 1'b0);
		check_byte("second byte at slave", 8'h3C, m_rx);
		issue(OP_ADDR, 10'h011, 1'b0, RW_READ, 8'h00, 1'b0);
		check_bit("absent slave nack", 1'b1, got_err);
		check_byte("address after Sr", {7'h11, RW_READ}, m_addr);
		check_bit("busy across Sr", 1'b1, busy);
		issue(OP_STOP, 10'h000, 1'b0, RW_WRITE, 8'h00, 1'b0);
		check_bit("idle after stop", 1'b0, busy);
		check_bit("data line high after stop", 1'b1, sda_bus);
		$display("test write7 done, failures %0d", failures);
	endtask

	// 10-bit read: header w, low byte, Sr, header r, one byte, STOP
	task automatic t_tenread();
		issue(OP_ADDR, SLAVE10, 1'b1, RW_READ, 8'h00, 1'b0);
		check_bit("ten-bit ack error", 1'b0, got_err);
		check_bit("slave selected", 1'b1, m_sel10);
		check_byte("header after Sr", {TEN_PREFIX, SLAVE10[9:8], RW_READ}, m_addr);
		issue(OP_READ, 10'h000, 1'b0, RW_READ, 8'h00, 1'b1);
		check_byte("read byte", SLAVE_TX, got_rdata);
		check_bit("no arbitration loss", 1'b0, got_arb);
		issue(OP_STOP, 10'h000, 1'b0, RW_WRITE, 8'h00, 1'b0);
		check_bit("idle after stop", 1'b0, busy);
		check_bit("selection dropped", 1'b0, m_sel10);
		$display("test tenread done, failures %0d", failures);
	endtask

	// Rival holds SDA low over the first address bit; engine must back off
	task automatic t_arb();
		int k;
		k = 0;
		fork
			issue(OP_ADDR, 10'h055, 1'b0, RW_WRITE, 8'h00, 1'b0);
			begin
				while (scl_oe !== 1'b1 && k < 2000) begin
					@(posedge clk);
					k++;
				end
				if (scl_oe !== 1'b1) begin
					check_bit("start before rival", 1'b1, scl_oe);
					print_verdict();
				end
				rival <= 1'b1;
			end
		join
		check_bit("arbitration lost", 1'b1, got_arb);
		check_bit("lines released on loss", 1'b0, scl_oe | sda_oe | scl_o | sda_o);
		check_bit("idle on loss", 1'b1, ready);
		@(posedge clk);
		rival <= 1'b0;
		repeat (20) @(posedge clk);
		check_bit("idle after rival stop", 1'b0, busy);
		issue(OP_STOP, 10'h000, 1'b0, RW_WRITE, 8'h00, 1'b0);
		check_bit("stop refused after loss", 1'b1, got_ref);
		$display("test arb done, failures %0d", failures);
	endtask

	// Main sequence
	initial begin
		resetn = 1'b0;
		valid = 1'b0;
		op = 2'h0;
		addr = 10'h000;
		ten = 1'b0;
		rw = 1'b0;
		data = 8'h00;
		nack = 1'b0;
		rival = 1'b0;
		failures = 0;
		checks = 0;
		repeat (8) @(posedge clk);
		check_bit("lines released in reset", 1'b0, scl_oe | sda_oe);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		t_refuse();
		t_write7();
		t_tenread();
		t_arb();
		print_verdict();
	end
endmodule // test_ibp_master
`default_nettype wire
